//--- rtl/switchgear_position_supervisor.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "sgps_cfg.svh"
module switchgear_position_supervisor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Auxiliary contacts (asynchronous pins)
  input wire logic i_aux_closed,
  input wire logic i_aux_open,
  // Command pulses
  input wire logic i_cmd_close,
  input wire logic i_cmd_open,
  // Validated position
  output logic [1:0] o_pos_code,
  output logic o_pos_closed,
  output logic o_pos_open,
  output logic o_pos_interm,
  output logic o_pos_disturb,
  output logic o_single_contact_flag,
  output logic o_command_success,
  // Interrupt
  output logic o_irq
);

  // ****************************************
  // Contact synchronisers
  // ****************************************
  logic [1:0] aux_pin;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] aux_q;
  assign aux_pin = {i_aux_open, i_aux_closed};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          sync1_q[g] <= 1'h0;
          sync2_q[g] <= 1'h0;
          sync3_q[g] <= 1'h0;
          aux_q[g] <= 1'h0;
        end else begin
          sync1_q[g] <= aux_pin[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          // Change accepted only once two stages agree
          // One-cycle pin pulses never agree, so they are dropped
          if (sync2_q[g] == sync3_q[g]) begin
            aux_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate

  wire logic cl = aux_q[0];
  wire logic op = aux_q[1];

  // ****************************************
  // APB decode
  // ****************************************
  sgps_pkg::cfg_s cfg_q;
  logic [`TMR_W-1:0] t_close_q;
  logic [`TMR_W-1:0] t_open_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;

  wire logic setup = i_psel & ~i_penable;
  // Writes land only on the ready edge
  wire logic wr_en = i_psel & i_penable & o_pready & i_pwrite;
  wire logic sel_ctrl = i_paddr == `ADDR_CTRL;
  wire logic sel_tcl = i_paddr == `ADDR_T_CLOSE;
  wire logic sel_top = i_paddr == `ADDR_T_OPEN;
  wire logic sel_stat = i_paddr == `ADDR_STATUS;
  wire logic sel_istat = i_paddr == `ADDR_IRQ_STAT;
  wire logic sel_imask = i_paddr == `ADDR_IRQ_MASK;
  wire logic mapped = sel_ctrl | sel_tcl | sel_top | sel_stat | sel_istat | sel_imask;

  // ****************************************
  // Travel supervision
  // ****************************************
  sgps_pkg::travel_e trv_q;
  logic [`TMR_W-1:0] cnt_q;
  logic fail_q;
  logic [1:0] fail_pat_q;

  wire logic sw_close = wr_en & sel_ctrl & i_pwdata[`CTRL_CMD_CLOSE];
  wire logic sw_open = wr_en & sel_ctrl & i_pwdata[`CTRL_CMD_OPEN];
  // ****************************************
  // Wiring checks
  // ****************************************
  // Missing assignment outranks any contact reading
  wire logic need_cl = cfg_q.mode != `MODE_OPEN_ONLY;
  wire logic need_op = cfg_q.mode != `MODE_CLOSED_ONLY;
  wire logic miss_cl = need_cl & ~cfg_q.closed_asg;
  wire logic miss_op = need_op & ~cfg_q.open_asg;
  wire logic unassigned = miss_cl | miss_op;
  // ****************************************
  // Command decode
  // ****************************************
  // command pulses, open wins a tie
  wire logic cmd_open = i_cmd_open | sw_open;
  wire logic cmd_close = (i_cmd_close | sw_close) & ~cmd_open;
  wire logic start_close = cmd_close & need_cl;
  wire logic start_open = cmd_open & need_op;
  wire logic running = trv_q != sgps_pkg::TRV_IDLE;

  // Raw position from contacts, with running choosing intermediate over disturbed
  logic [1:0] raw_code;
  assign raw_code = (cfg_q.mode == `MODE_CLOSED_ONLY) ? (cl ? `CODE_CLOSED : `CODE_OPEN) :
                    (cfg_q.mode == `MODE_OPEN_ONLY) ? (op ? `CODE_OPEN : `CODE_CLOSED) :
                    (cl & ~op) ? `CODE_CLOSED :
                    (~cl & op) ? `CODE_OPEN :
                    running ? `CODE_INTERM : `CODE_DISTURB;

  wire logic reached = (trv_q == sgps_pkg::TRV_CLOSING && raw_code == `CODE_CLOSED) ||
                       (trv_q == sgps_pkg::TRV_OPENING && raw_code == `CODE_OPEN);
  wire logic ev_success = running & reached;
  // No success claimed while an assignment is missing
  wire logic ok_evt = ev_success & ~unassigned;
  // Zero is still a live count, so expiry takes T+1 cycles
  // expiry before end position
  wire logic ev_fail = running & ~reached & (cnt_q == {`TMR_W{1'b0}});
  // Disturbed holds until the contacts move or a new command starts
  wire logic fail_hold = fail_q & (aux_q == fail_pat_q);

  logic [1:0] code_d;
  assign code_d = unassigned ? `CODE_DISTURB :
                  (running & ~reached) ? `CODE_INTERM :
                  fail_hold ? `CODE_DISTURB : raw_code;

  function automatic sgps_pkg::pos_s pos_of(input logic [1:0] c);
    sgps_pkg::pos_s p;
    p.code = c;
    p.closed = c == `CODE_CLOSED;
    p.open = c == `CODE_OPEN;
    p.interm = c == `CODE_INTERM;
    p.disturb = c == `CODE_DISTURB;
    return p;
  endfunction

  wire sgps_pkg::pos_s pos_d = pos_of(code_d);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      trv_q <= sgps_pkg::TRV_IDLE;
      cnt_q <= {`TMR_W{1'b0}};
    end else begin
      if (start_open) begin
        trv_q <= sgps_pkg::TRV_OPENING;
        cnt_q <= t_open_q;
      end else if (start_close) begin
        trv_q <= sgps_pkg::TRV_CLOSING;
        cnt_q <= t_close_q;
      end else if (ev_success | ev_fail) begin
        trv_q <= sgps_pkg::TRV_IDLE;
      end else if (running) begin
        cnt_q <= cnt_q - `TMR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      fail_q <= 1'h0;
      fail_pat_q <= 2'h0;
    end else if (start_open | start_close) begin
      fail_q <= 1'h0;
    end else if (ev_fail) begin
      fail_q <= 1'h1;
      fail_pat_q <= aux_q;
    end else if (!fail_hold) begin
      fail_q <= 1'h0;
    end
  end

  // ****************************************
  // Position outputs
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // Nothing known about the gear yet
      o_pos_code <= `CODE_DISTURB;
      o_pos_closed <= 1'h0;
      o_pos_open <= 1'h0;
      o_pos_interm <= 1'h0;
      o_pos_disturb <= 1'h1;
      o_single_contact_flag <= 1'h0;
      o_command_success <= 1'h0;
    end else begin
      o_pos_code <= pos_d.code;
      o_pos_closed <= pos_d.closed;
      o_pos_open <= pos_d.open;
      o_pos_interm <= pos_d.interm;
      o_pos_disturb <= pos_d.disturb;
      o_single_contact_flag <= cfg_q.mode != `MODE_TWO;
      o_command_success <= ok_evt;
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  // Registered code against its next value flags every change once
  wire logic code_chg = o_pos_code != pos_d.code;
  wire logic [`IRQ_W-1:0] irq_set = {code_chg, ev_fail, ok_evt};
  wire logic [`IRQ_W-1:0] irq_clr = (wr_en & sel_istat) ? i_pwdata[`IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= sgps_pkg::cfg_s'(`RST_CTRL);
      t_close_q <= `RST_T_CLOSE;
      t_open_q <= `RST_T_OPEN;
      irq_mask_q <= `RST_MASK;
      irq_stat_q <= '0;
    end else begin
      if (wr_en & sel_ctrl) begin
        cfg_q <= sgps_pkg::cfg_s'(i_pwdata[$bits(sgps_pkg::cfg_s)-1:0]);
      end
      if (wr_en & sel_tcl) begin
        t_close_q <= i_pwdata[`TMR_W-1:0];
      end
      if (wr_en & sel_top) begin
        t_open_q <= i_pwdata[`TMR_W-1:0];
      end
      if (wr_en & sel_imask) begin
        irq_mask_q <= i_pwdata[`IRQ_W-1:0];
      end
      // Set wins over a same-cycle clear
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  logic [7:0] status_byte;
  // Running lets software tell travel from a stuck contact
  assign status_byte = {running, o_command_success, o_single_contact_flag, o_pos_disturb,
                        o_pos_interm, o_pos_open, o_pos_code};

  logic [31:0] rdata;
  assign rdata = sel_ctrl ? {28'h0, cfg_q} :
                 sel_tcl ? {8'h0, t_close_q} :
                 sel_top ? {8'h0, t_open_q} :
                 sel_stat ? {24'h0, status_byte} :
                 sel_istat ? {29'h0, irq_stat_q} :
                 sel_imask ? {29'h0, irq_mask_q} : 32'h0;

  // Zero wait: answer is ready in the first access cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'h0;
      o_pslverr <= 1'h0;
      o_prdata <= 32'h0;
      o_irq <= 1'h0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~mapped;
      o_prdata <= (setup & ~i_pwrite) ? rdata : 32'h0;
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // switchgear_position_supervisor

//--- rtl/sgps_cfg.svh
`ifndef SGPS_CFG_SVH
`define SGPS_CFG_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define ADDR_CTRL 12'h000
`define ADDR_T_CLOSE 12'h004
`define ADDR_T_OPEN 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_IRQ_STAT 12'h010
`define ADDR_IRQ_MASK 12'h014
// ****************************************
// Field positions and widths
// ****************************************
`define TMR_W 24
`define CTRL_CMD_CLOSE 4
`define CTRL_CMD_OPEN 5
`define IRQ_W 3
`define IRQ_SUCCESS 0
`define IRQ_FAIL 1
`define IRQ_POS_CHG 2
// ****************************************
// Wiring modes and position codes
// ****************************************
`define MODE_TWO 2'h0
`define MODE_CLOSED_ONLY 2'h1
`define MODE_OPEN_ONLY 2'h2
`define CODE_INTERM 2'h0
`define CODE_OPEN 2'h1
`define CODE_CLOSED 2'h2
`define CODE_DISTURB 2'h3
// ****************************************
// Reset values
// ****************************************
`define RST_CTRL 4'hC
`define RST_T_CLOSE 24'h0F4240
`define RST_T_OPEN 24'h0F4240
`define RST_MASK 3'h0
`endif

//--- rtl/sgps_pkg.sv
package sgps_pkg;
  // Wiring configuration held in the control register
  typedef struct packed {
    logic open_asg;
    logic closed_asg;
    logic [1:0] mode;
  } cfg_s;
  // Validated position view
  typedef struct packed {
    logic [1:0] code;
    logic closed;
    logic open;
    logic interm;
    logic disturb;
  } pos_s;
  typedef enum logic [1:0] {TRV_IDLE, TRV_CLOSING, TRV_OPENING} travel_e;
endpackage

//--- tb/sgps_monitor.sv
`timescale 1ns/1ns
`include "sgps_cfg.svh"
module sgps_monitor (
  // Clock, reset and bus
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  // Position view
  input wire logic [1:0] o_pos_code,
  input wire logic o_pos_closed,
  input wire logic o_pos_open,
  input wire logic o_pos_interm,
  input wire logic o_pos_disturb,
  input wire logic o_command_success
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Zero-wait slave, so ready must follow every setup
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_idle_rdata_zero: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  a_closed_decode: assert property (o_pos_closed == (o_pos_code == `CODE_CLOSED))
    else $error("closed flag disagrees with code");
  a_open_decode: assert property (o_pos_open == (o_pos_code == `CODE_OPEN))
    else $error("open flag disagrees with code");
  a_interm_decode: assert property (o_pos_interm == (o_pos_code == `CODE_INTERM))
    else $error("intermediate flag disagrees with code");
  a_disturb_decode: assert property (o_pos_disturb == (o_pos_code == `CODE_DISTURB))
    else $error("disturbed flag disagrees with code");
  a_success_at_end: assert property (o_command_success |-> o_pos_code inside {2'h1, 2'h2}
    ##1 !o_command_success)
    else $error("success pulse wrong");
endmodule // sgps_monitor

//--- tb/aux_contact_model.sv
`timescale 1ns/1ns
module aux_contact_model (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [1:0] i_pat,
  input wire logic [7:0] i_delay,
  output logic o_aux_closed,
  output logic o_aux_open
);
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] tgt_q = 2'h0;
  logic [1:0] pos_q = 2'h0;
  // Both contacts open in mid-travel, as on real gear
  always_ff @(posedge i_clk_sys) begin
    if (i_go) begin
      cnt_q <= i_delay;
      tgt_q <= i_pat;
      pos_q <= (i_delay == 8'h00) ? i_pat : 2'h0;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) pos_q <= tgt_q;
    end
  end
  assign o_aux_closed = pos_q[1];
  assign o_aux_open = pos_q[0];
endmodule // aux_contact_model

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "sgps_cfg.svh"
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic i_cmd_close = 1'b0, i_cmd_open = 1'b0, go = 1'b0;
  logic [1:0] pat = 2'h0, o_pos_code;
  logic [7:0] dly = 8'h00;
  logic o_pready, o_pslverr, i_aux_closed, i_aux_open, rerr, o_irq;
  logic o_pos_closed, o_pos_open, o_pos_interm, o_pos_disturb;
  logic o_single_contact_flag, o_command_success;
  int errors = 0, total_checks = 0, cyc = 0;
  // Rows: {closed contact, open contact, expected code}
  localparam logic [3:0] ROWS [4] = '{4'h3, 4'hF, 4'hA, 4'h5};
  localparam logic [31:0] UNASG [3] = '{32'h2, 32'h1, 32'h8};
  switchgear_position_supervisor i_switchgear_position_supervisor (.i_clk_sys, .i_nrst,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_aux_closed, .i_aux_open, .i_cmd_close, .i_cmd_open, .o_pos_code, .o_pos_closed,
    .o_pos_open, .o_pos_interm, .o_pos_disturb, .o_single_contact_flag, .o_command_success,
    .o_irq);
  aux_contact_model i_aux_contact_model (.i_clk_sys, .i_go(go), .i_pat(pat), .i_delay(dly),
    .o_aux_closed(i_aux_closed), .o_aux_open(i_aux_open));
  always #20 i_clk_sys = ~i_clk_sys;
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic note(input string m);
    errors++;
    $display("unexpected t=%0t %s", $time, m);
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    total_checks++;
    if (g !== e) note(m);
  endtask
  task automatic chk_code(input logic [1:0] g, input logic [1:0] e, input string m);
    total_checks++;
    if (g !== e) note(m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) note(m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) note("no ready");
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Command pulse {close, open} with the gear moving to p after d cycles
  task automatic move(input logic [1:0] c, input logic [1:0] p, input logic [7:0] d);
    @(posedge i_clk_sys);
    {i_cmd_close, i_cmd_open} <= c;
    go <= 1'b1;
    pat <= p;
    dly <= d;
    @(posedge i_clk_sys);
    {i_cmd_close, i_cmd_open} <= 2'h0;
    go <= 1'b0;
  endtask
  task automatic wait_ok;
    for (int n = 0; n < 40 && o_command_success !== 1'b1; n++) @(posedge i_clk_sys);
  endtask
  initial begin
    tick(12);
    chk_code(o_pos_code, `CODE_DISTURB, "code in reset");
    i_nrst <= 1'b1;
    foreach (ROWS[k]) begin
      move(2'h0, ROWS[k][3:2], 8'h00);
      tick(8);
      chk_code(o_pos_code, ROWS[k][1:0], "row code");
    end
    $display("test rows done");
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk_word(rdat, {28'h0, `RST_CTRL}, "ctrl reset");
    apb(1'b0, `ADDR_T_CLOSE, 32'h0);
    chk_word(rdat, {8'h0, `RST_T_CLOSE}, "close time reset");
    apb(1'b0, `ADDR_IRQ_MASK, 32'h0);
    chk_word(rdat, {29'h0, `RST_MASK}, "mask reset");
    apb(1'b0, 12'h018, 32'h0);
    chk_bit(rerr, 1'b1, "unmapped no error");
    chk_word(rdat, 32'h0, "unmapped data");
    $display("test registers done");
    apb(1'b1, `ADDR_T_CLOSE, 32'h14);
    apb(1'b1, `ADDR_T_OPEN, 32'h14);
    move(2'h2, 2'h2, 8'h06);
    tick(2);
    chk_code(o_pos_code, `CODE_INTERM, "close travel");
    wait_ok();
    chk_bit(o_command_success, 1'b1, "close no success");
    chk_code(o_pos_code, `CODE_CLOSED, "close end");
    move(2'h1, 2'h1, 8'h3C);
    tick(2);
    chk_code(o_pos_code, `CODE_INTERM, "open travel");
    tick(28);
    chk_code(o_pos_code, `CODE_DISTURB, "open expiry");
    tick(45);
    chk_code(o_pos_code, `CODE_OPEN, "late open");
    apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
    tick(2);
    chk_bit(o_irq, 1'b1, "irq not raised");
    apb(1'b1, `ADDR_IRQ_STAT, 32'h7);
    tick(2);
    chk_bit(o_irq, 1'b0, "irq not cleared");
    $display("test two contact done");
    apb(1'b1, `ADDR_CTRL, 32'h5);
    tick(3);
    chk_bit(o_single_contact_flag, 1'b1, "single flag");
    move(2'h2, 2'h2, 8'h04);
    wait_ok();
    chk_bit(o_command_success, 1'b1, "single no success");
    chk_code(o_pos_code, `CODE_CLOSED, "single end");
    move(2'h1, 2'h2, 8'h00);
    tick(3);
    chk_code(o_pos_code, `CODE_CLOSED, "open not ignored");
    apb(1'b1, `ADDR_CTRL, 32'hA);
    move(2'h1, 2'h1, 8'h3C);
    tick(2);
    chk_code(o_pos_code, `CODE_INTERM, "open only travel");
    tick(28);
    chk_code(o_pos_code, `CODE_DISTURB, "open only expiry");
    chk_bit(o_pos_interm, 1'b0, "interm after expiry");
    foreach (UNASG[k]) begin
      apb(1'b1, `ADDR_CTRL, UNASG[k]);
      tick(3);
      chk_code(o_pos_code, `CODE_DISTURB, "unassigned contact");
    end
    $display("test single contact done");
    i_nrst <= 1'b0;
    tick(2);
    chk_code(o_pos_code, `CODE_DISTURB, "code in mid reset");
    chk_bit(o_irq, 1'b0, "irq in reset");
    chk_bit(o_pready, 1'b0, "ready in reset");
    i_nrst <= 1'b1;
    apb(1'b0, `ADDR_T_OPEN, 32'h0);
    chk_word(rdat, {8'h0, `RST_T_OPEN}, "open time reset");
    $display("test reset done");
    move(2'h0, 2'h1, 8'h00);
    tick(8);
    chk_code(o_pos_code, `CODE_OPEN, "open contacts");
    apb(1'b1, `ADDR_CTRL, {28'h0, `RST_CTRL} | (32'h1 << `CTRL_CMD_CLOSE));
    tick(2);
    chk_code(o_pos_code, `CODE_INTERM, "close bit travel");
    apb(1'b1, `ADDR_CTRL, {28'h0, `RST_CTRL} | (32'h1 << `CTRL_CMD_OPEN));
    wait_ok();
    chk_bit(o_command_success, 1'b1, "open bit no success");
    chk_code(o_pos_code, `CODE_OPEN, "open bit end");
    $display("test command bits done");
    wrap_up();
  end
endmodule // tb_top
bind switchgear_position_supervisor sgps_monitor i_sgps_monitor (.i_clk_sys, .i_nrst,
  .i_psel, .i_penable, .o_pready, .o_pslverr, .o_prdata, .o_pos_code, .o_pos_closed,
  .o_pos_open, .o_pos_interm, .o_pos_disturb, .o_command_success);
